// File: drc_diag_record.sv
// Extended diagnostic record builder, alarm-input and counter variants
`timescale 1ns/1ps
`default_nettype none
`include "drc_diag_params.svh"

module drc_diag_record (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  // Configuration
  input  wire drc_pkg::drc_variant_t  i_variant,
  input  wire logic                   i_more_types,
  input  wire logic                   i_diag_release,
  // Basic record, held by the caller
  input  wire drc_pkg::drc_basic_t    i_basic,
  // Live error levels
  input  wire logic [3:0]             i_grp_err,
  input  wire logic [3:0]             i_cnt_err,
  // Lost-interrupt event pulses
  input  wire logic [`DRC_NUM_DI-1:0] i_di_lost,
  input  wire drc_pkg::drc_cnt_lost_t i_cnt_lost,
  // Clear of sticky lost flags
  input  wire logic                   i_lost_clr,
  // Record read port
  input  wire logic                   i_rd_req,
  input  wire logic [`DRC_IDX_W-1:0]  i_rd_idx,
  output logic                        o_rd_valid,
  output logic [7:0]                  o_rd_data,
  // Status
  output logic                        o_rec_ready,
  output logic                        o_diag_event,
  output logic                        o_lost_any
);

  import drc_pkg::*;

  // ============================================================
  // Sticky lost-interrupt flags
  logic [`DRC_NUM_DI-1:0] di_lost;
  logic [`DRC_NUM_DI-1:0] next_di_lost;
  drc_cnt_lost_t          cnt_lost;
  drc_cnt_lost_t          next_cnt_lost;
  drc_variant_t           variant_q;
  logic                   variant_chg;
  logic                   lost_drop;

  assign variant_chg   = (i_variant != variant_q);
  assign lost_drop     = i_lost_clr | variant_chg;
  // Set wins over clear; a variant change drops stale flags
  assign next_di_lost  = i_di_lost | (lost_drop ? '0 : di_lost);
  assign next_cnt_lost = i_cnt_lost | (lost_drop ? '0 : cnt_lost);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      di_lost <= '0;
    end else begin
      di_lost <= next_di_lost;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_lost <= '0;
    end else begin
      cnt_lost <= next_cnt_lost;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      variant_q <= DRC_VAR_ALARM;
    end else begin
      variant_q <= i_variant;
    end
  end

  // ============================================================
  // Lost-interrupt summary
  // Only flags of the variant in use are reported
  assign o_lost_any = (variant_q == DRC_VAR_ALARM) ? (|di_lost) : (|cnt_lost);

  // ============================================================
  // Basic record gating and change detection
  drc_basic_t basic_q;
  logic       release_q;
  logic       basic_chg;
  logic       release_off;
  logic       next_diag_event;
  drc_basic_t basic_out;

  assign basic_chg       = (i_basic != basic_q);
  assign release_off     = release_q & ~i_diag_release;
  // Incoming and outgoing messages both need release
  assign next_diag_event = i_diag_release & basic_chg;
  assign basic_out       = release_q ? basic_q : '0;

  // Previous basic record, kept for change detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      basic_q <= '0;
    end else begin
      basic_q <= i_basic;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      release_q <= 1'b0;
    end else begin
      release_q <= i_diag_release;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_diag_event <= 1'b0;
    end else begin
      o_diag_event <= next_diag_event;
    end
  end

  // ============================================================
  // Byte builders
  function automatic logic [7:0] drc_di_byte(input logic [3:0] lost);
    // Even bits carry flags, odd bits fixed zero
    logic [7:0] b;
    b = `DRC_ZERO_BYTE;
    for (int i = 0; i < `DRC_DI_PER_BYTE; i++) begin
      b[i*`DRC_DI_BIT_STEP] = lost[i];
    end
    drc_di_byte = b;
  endfunction : drc_di_byte

  function automatic logic [7:0] drc_cnt_byte(input logic ovf, input logic cmp);
    drc_cnt_byte = {`DRC_ZERO_NIB, cmp, ovf, `DRC_ZERO_2};
  endfunction : drc_cnt_byte

  function automatic logic [7:0] drc_cnt3_byte(input drc_cnt_lost_t lost);
    // Counter 3 adds gate and latch flags; top bits fixed zero
    drc_cnt3_byte = {`DRC_ZERO_3, lost.latch3, lost.cmp3, lost.ovf3,
                     lost.gate_close3, lost.gate_open3};
  endfunction : drc_cnt3_byte

  logic [7:0] di_byte  [0:3];
  logic [7:0] cnt_byte [0:3];

  genvar g;
  generate
    for (g = 0; g < `DRC_LOST_BYTES; g++) begin : g_lost
      assign di_byte[g] = drc_di_byte(di_lost[g*`DRC_DI_PER_BYTE +: `DRC_DI_PER_BYTE]);
      if (g < `DRC_CNT_PLAIN) begin : g_cnt
        assign cnt_byte[g] = drc_cnt_byte(cnt_lost.ovf[g], cnt_lost.cmp[g]);
      end else begin : g_cnt3
        assign cnt_byte[g] = drc_cnt3_byte(cnt_lost);
      end
    end
  endgenerate

  // ============================================================
  // Record byte selection
  logic                  is_alarm;
  logic [6:0]            ch_type;
  logic [7:0]            byte_ch_type;
  logic [7:0]            byte_num_ch;
  logic [7:0]            byte_grp_err;
  logic [`DRC_IDX_W-1:0] wr_idx;
  logic [7:0]            wr_byte;
  logic [1:0]            lost_sel;
  logic [7:0]            lost_byte;
  logic [7:0]            byte_bits_ch;

  assign is_alarm     = (variant_q == DRC_VAR_ALARM);
  assign ch_type      = is_alarm ? `DRC_CH_TYPE_DI : `DRC_CH_TYPE_FM;
  assign byte_ch_type = {i_more_types, ch_type};
  assign byte_num_ch  = is_alarm ? `DRC_NUM_CH_DI : `DRC_NUM_CH_CNT;
  assign byte_grp_err = {`DRC_ZERO_NIB,
                         is_alarm ? i_grp_err : i_cnt_err};
  assign lost_sel     = wr_idx[1:0];
  assign byte_bits_ch = `DRC_BITS_PER_CH;
  // Lost byte follows the registered variant
  assign lost_byte    = is_alarm ? di_byte[lost_sel] : cnt_byte[lost_sel];

  always_comb begin
    case (wr_idx)
      `DRC_IDX_BASIC0:  wr_byte = basic_out.b0;
      `DRC_IDX_BASIC1:  wr_byte = basic_out.b1;
      `DRC_IDX_BASIC2:  wr_byte = basic_out.b2;
      `DRC_IDX_BASIC3:  wr_byte = basic_out.b3;
      `DRC_IDX_CH_TYPE: wr_byte = byte_ch_type;
      `DRC_IDX_BITS_CH: wr_byte = byte_bits_ch;
      `DRC_IDX_NUM_CH:  wr_byte = byte_num_ch;
      `DRC_IDX_GRP_ERR: wr_byte = byte_grp_err;
      `DRC_IDX_LOST0,
      `DRC_IDX_LOST1,
      `DRC_IDX_LOST2,
      `DRC_IDX_LOST3:   wr_byte = lost_byte;
      default:          wr_byte = `DRC_ZERO_BYTE;
    endcase
  end

  // ============================================================
  // Refresh sequencer: rewrites all sixteen bytes in a loop
  drc_state_t state;
  drc_state_t next_state;
  logic       wr_last;
  logic       next_rec_ready;

  assign wr_last = (wr_idx == `DRC_IDX_LAST);

  always_comb begin
    case (state)
      DRC_ST_IDLE: begin
        next_state = DRC_ST_FILL;
      end
      DRC_ST_FILL: begin
        next_state = wr_last ? DRC_ST_READY : DRC_ST_FILL;
      end
      DRC_ST_READY: begin
        next_state = DRC_ST_READY;
      end
      default: begin
        next_state = DRC_ST_IDLE;
      end
    endcase
  end

  logic                  restart;
  logic [`DRC_IDX_W-1:0] next_wr_idx;

  // Variant change or release loss refills the record from byte 0
  assign restart        = release_off | variant_chg;
  assign next_wr_idx    = (state == DRC_ST_IDLE) ? '0 : wr_idx + 1'b1;
  // Ready once a full pass has landed, dropped on restart
  assign next_rec_ready = (next_state == DRC_ST_READY) & ~restart;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= DRC_ST_IDLE;
    end else begin
      state <= restart ? DRC_ST_IDLE : next_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_idx <= '0;
    end else begin
      wr_idx <= next_wr_idx;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rec_ready <= 1'b0;
    end else begin
      o_rec_ready <= next_rec_ready;
    end
  end

  // ============================================================
  // Record store and read port
  logic wr_en;

  // Every non-idle cycle rewrites one byte
  assign wr_en = (state != DRC_ST_IDLE);

  drc_rec_mem u_mem (
    .i_mclk  (i_mclk),
    .i_we    (wr_en),
    .i_waddr (wr_idx),
    .i_wdata (wr_byte),
    .i_re    (i_rd_req),
    .i_raddr (i_rd_idx),
    .o_rdata (o_rd_data)
  );

  // Valid trails a taken read by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_req;
    end
  end

endmodule : drc_diag_record
`default_nettype wire

// File: drc_diag_params.svh
// Constants of the extended diagnostic record builder
`ifndef DRC_DIAG_PARAMS_SVH
`define DRC_DIAG_PARAMS_SVH

// ============================================================
// Record layout
`define DRC_REC_BYTES      16
`define DRC_IDX_W          4
`define DRC_BASIC_BYTES    4
`define DRC_IDX_BASIC0     4'h0
`define DRC_IDX_BASIC1     4'h1
`define DRC_IDX_BASIC2     4'h2
`define DRC_IDX_BASIC3     4'h3
`define DRC_IDX_CH_TYPE    4'h4
`define DRC_IDX_BITS_CH    4'h5
`define DRC_IDX_NUM_CH     4'h6
`define DRC_IDX_GRP_ERR    4'h7
`define DRC_IDX_LOST0      4'h8
`define DRC_IDX_LOST1      4'h9
`define DRC_IDX_LOST2      4'hA
`define DRC_IDX_LOST3      4'hB
`define DRC_IDX_LAST       4'hF

// ============================================================
// Field values
`define DRC_CH_TYPE_DI     7'h70
`define DRC_CH_TYPE_FM     7'h76
`define DRC_BITS_PER_CH    8'h08
`define DRC_NUM_CH_DI      8'h08
`define DRC_NUM_CH_CNT     8'h04
`define DRC_ZERO_BYTE      8'h00
`define DRC_ZERO_NIB       4'h0
`define DRC_ZERO_3         3'h0
`define DRC_ZERO_2         2'h0
`define DRC_NUM_DI         16
`define DRC_DI_PER_BYTE    4
`define DRC_DI_BIT_STEP    2
`define DRC_LOST_BYTES     4
`define DRC_CNT_PLAIN      3

`endif

// File: drc_pkg.sv
// Types of the extended diagnostic record builder
package drc_pkg;

  // ============================================================
  // Basic record, bytes 0 to 3
  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } drc_basic_t;

  // ============================================================
  // Counter lost-interrupt events, one-cycle pulses
  typedef struct packed {
    logic       latch3;
    logic       cmp3;
    logic       ovf3;
    logic       gate_close3;
    logic       gate_open3;
    logic [2:0] cmp;
    logic [2:0] ovf;
  } drc_cnt_lost_t;

  // ============================================================
  // Record variant
  typedef enum logic {
    DRC_VAR_ALARM,
    DRC_VAR_COUNTER
  } drc_variant_t;

  // ============================================================
  // Refresh sequencer
  typedef enum logic [1:0] {
    DRC_ST_IDLE,
    DRC_ST_FILL,
    DRC_ST_READY
  } drc_state_t;

endpackage : drc_pkg

// File: drc_rec_mem.sv
// Sixteen-byte record store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "drc_diag_params.svh"

module drc_rec_mem (
  // Clock
  input  wire logic                   i_mclk,
  // Write port
  input  wire logic                   i_we,
  input  wire logic [`DRC_IDX_W-1:0]  i_waddr,
  input  wire logic [7:0]             i_wdata,
  // Read port
  input  wire logic                   i_re,
  input  wire logic [`DRC_IDX_W-1:0]  i_raddr,
  output var  logic [7:0]             o_rdata
);

  logic [7:0] mem [0:`DRC_REC_BYTES-1];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : drc_rec_mem
`default_nettype wire

// File: drc_diag_record_monitor.sv
// Port checker of the diagnostic record builder
`timescale 1ns/1ps
`default_nettype none
`include "drc_diag_params.svh"
module drc_diag_record_chk (
  // Clock and reset
  input wire logic                  i_mclk,
  input wire logic                  i_rst,
  // Inputs
  input wire drc_pkg::drc_variant_t i_variant,
  input wire logic                  i_diag_release,
  input wire drc_pkg::drc_basic_t   i_basic,
  input wire logic                  i_rd_req,
  input wire logic [`DRC_IDX_W-1:0] i_rd_idx,
  // Outputs
  input wire logic                  o_rd_valid,
  input wire logic [7:0]            o_rd_data,
  input wire logic                  o_rec_ready,
  input wire logic                  o_diag_event
);
  import drc_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ============================================================
  // Settling age counters
  logic [4:0] var_age;
  logic [4:0] lo_age;
  logic       var_q;
  wire        settled = o_rec_ready && var_age > 5'h17;
  always_ff @(posedge i_mclk) begin
    var_q   <= i_variant;
    var_age <= (i_rst || i_variant != var_q) ? 5'h0 : var_age + {4'h0, var_age != 5'h1F};
    lo_age  <= (i_rst || i_diag_release) ? 5'h0 : lo_age + {4'h0, lo_age != 5'h1F};
  end
  sequence s_rd(logic [3:0] idx);
    settled && i_rd_req && i_rd_idx == idx;
  endsequence
  // ============================================================
  // Assertions
  a_rd_answer: assert property (i_rd_req |=> o_rd_valid)
    else $error("read not answered");
  a_rd_quiet: assert property (!i_rd_req |=> !o_rd_valid)
    else $error("valid without read");
  a_chan_type: assert property (s_rd(4'h4) |=> o_rd_data[6:0] ==
    ($past(i_variant) == DRC_VAR_ALARM ? 7'h70 : 7'h76)) else $error("channel type wrong");
  a_bits_per_ch: assert property (s_rd(4'h5) |=> o_rd_data == 8'h08)
    else $error("bits per channel wrong");
  a_chan_count: assert property (s_rd(4'h6) |=> o_rd_data ==
    ($past(i_variant) == DRC_VAR_ALARM ? 8'h08 : 8'h04)) else $error("channel count wrong");
  a_group_upper: assert property (s_rd(4'h7) |=> o_rd_data[7:4] == 4'h0)
    else $error("byte 7 upper bits set");
  a_lost_fixed: assert property (settled && i_rd_req && i_rd_idx[3:2] == 2'h2 |=>
    (o_rd_data & ($past(i_variant) == DRC_VAR_ALARM ? 8'hAA :
    ($past(i_rd_idx) == 4'hB ? 8'hE0 : 8'hF3))) == 8'h00) else $error("fixed lost bit set");
  a_tail_zero: assert property (settled && i_rd_req && i_rd_idx[3:2] == 2'h3 |=>
    o_rd_data == 8'h00) else $error("tail byte not zero");
  a_basic_gated: assert property (o_rec_ready && lo_age > 5'h17 && i_rd_req &&
    i_rd_idx[3:2] == 2'h0 |=> o_rd_data == 8'h00) else $error("basic byte without release");
  a_event_cause: assert property ($changed(i_basic) && i_diag_release |=> o_diag_event)
    else $error("event missing");
  a_event_gated: assert property (!i_diag_release |=> !o_diag_event)
    else $error("event without release");
endmodule : drc_diag_record_chk
bind drc_diag_record drc_diag_record_chk drc_diag_record_chk_i (.i_mclk, .i_rst, .i_variant,
  .i_diag_release, .i_basic, .i_rd_req, .i_rd_idx, .o_rd_valid, .o_rd_data, .o_rec_ready,
  .o_diag_event);
`default_nettype wire

// File: tb_drc_diag_record.sv
// Self-checking bench of the diagnostic record builder
`timescale 1ns/1ps
`default_nettype none
`include "drc_diag_params.svh"
module tb_drc_diag_record;
  import drc_pkg::*;
  logic          i_mclk, i_rst, i_more_types, i_diag_release, i_lost_clr, i_rd_req;
  drc_variant_t  i_variant;
  drc_basic_t    i_basic;
  logic [3:0]    i_grp_err, i_cnt_err, i_rd_idx;
  logic [15:0]   i_di_lost;
  drc_cnt_lost_t i_cnt_lost;
  logic          o_rd_valid, o_rec_ready, o_diag_event, o_lost_any;
  logic [7:0]    o_rd_data;
  logic [7:0]    rec [16];
  logic [7:0]    ex  [16];
  int            fails, tests_run, n;
  drc_diag_record drc_diag_record_i (.i_mclk, .i_rst, .i_variant, .i_more_types,
    .i_diag_release, .i_basic, .i_grp_err, .i_cnt_err, .i_di_lost, .i_cnt_lost, .i_lost_clr,
    .i_rd_req, .i_rd_idx, .o_rd_valid, .o_rd_data, .o_rec_ready, .o_diag_event, .o_lost_any);
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // ============================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic read_rec;
    n = 0;
    repeat (24) @(posedge i_mclk);
    while (o_rec_ready !== 1'b1) begin
      @(posedge i_mclk);
      n++;
      if (n > 100) begin
        fails++;
        give_verdict();
      end
    end
    for (int k = 0; k < 18; k++) begin
      if (k > 1) begin
        chk({7'h0, o_rd_valid}, 8'h01);
        rec[k-2] = o_rd_data;
      end
      i_rd_req <= (k < 16);
      i_rd_idx <= k[3:0];
      @(posedge i_mclk);
    end
  endtask : read_rec
  task automatic set_ex(input drc_variant_t v);
    for (int k = 0; k < 16; k++) ex[k] = 8'h00;
    ex[4] = {i_more_types, (v == DRC_VAR_ALARM) ? 7'h70 : 7'h76};
    ex[5] = 8'h08;
    ex[6] = (v == DRC_VAR_ALARM) ? 8'h08 : 8'h04;
  endtask : set_ex
  task automatic cmp_rec;
    for (int k = 0; k < 4; k++) chk(rec[k], ex[k]);
    chk(rec[4], ex[4]);
    chk(rec[5], ex[5]);
    chk(rec[6], ex[6]);
    chk(rec[7], ex[7]);
    for (int k = 8; k < 12; k++) chk(rec[k], ex[k]);
    for (int k = 12; k < 16; k++) chk(rec[k], ex[k]);
  endtask : cmp_rec
  // ============================================================
  // Scenarios
  task automatic t_alarm;
    i_grp_err <= 4'h9;
    i_di_lost <= 16'h8421;
    @(posedge i_mclk);
    i_di_lost <= 16'h0;
    read_rec();
    set_ex(DRC_VAR_ALARM);
    ex[7] = 8'h09;
    ex[8] = 8'h01;
    ex[9] = 8'h04;
    ex[10] = 8'h10;
    ex[11] = 8'h40;
    cmp_rec();
    chk({7'h0, o_lost_any}, 8'h01);
    i_lost_clr <= 1'b1;
    @(posedge i_mclk);
    i_lost_clr <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk({7'h0, o_lost_any}, 8'h00);
    i_di_lost <= 16'h0002;
    i_lost_clr <= 1'b1;
    @(posedge i_mclk);
    i_di_lost <= 16'h0000;
    i_lost_clr <= 1'b0;
    @(posedge i_mclk);
    chk({7'h0, o_lost_any}, 8'h01);
    $display("alarm test done");
  endtask : t_alarm
  task automatic t_counter;
    i_variant <= DRC_VAR_COUNTER;
    i_more_types <= 1'b1;
    i_cnt_err <= 4'h6;
    repeat (4) @(posedge i_mclk);
    i_cnt_lost <= '{latch3: 1'b1, cmp3: 1'b0, ovf3: 1'b0, gate_close3: 1'b1,
                    gate_open3: 1'b0, cmp: 3'h1, ovf: 3'h6};
    @(posedge i_mclk);
    i_cnt_lost <= '0;
    read_rec();
    set_ex(DRC_VAR_COUNTER);
    ex[7] = 8'h06;
    ex[8] = 8'h08;
    ex[9] = 8'h04;
    ex[10] = 8'h04;
    ex[11] = 8'h12;
    cmp_rec();
    chk({7'h0, o_lost_any}, 8'h01);
    $display("counter test done");
  endtask : t_counter
  task automatic t_basic;
    i_diag_release <= 1'b1;
    @(posedge i_mclk);
    i_basic <= 32'hA5C3_0F81;
    n = 0;
    while (o_diag_event !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      n++;
    end
    chk({7'h0, o_diag_event}, 8'h01);
    read_rec();
    set_ex(i_variant);
    ex[0] = 8'h81;
    ex[1] = 8'h0F;
    ex[2] = 8'hC3;
    ex[3] = 8'hA5;
    ex[7] = 8'h06;
    ex[9] = 8'h04;
    ex[10] = 8'h04;
    ex[11] = 8'h12;
    ex[8] = 8'h08;
    cmp_rec();
    i_diag_release <= 1'b0;
    @(posedge i_mclk);
    i_basic <= 32'h1234_5678;
    repeat (2) @(posedge i_mclk);
    chk({7'h0, o_diag_event}, 8'h00);
    read_rec();
    for (int k = 0; k < 4; k++) ex[k] = 8'h00;
    cmp_rec();
    $display("basic record test done");
  endtask : t_basic
  initial begin
    {i_rst, i_more_types, i_diag_release, i_lost_clr, i_rd_req} = 5'h10;
    {i_grp_err, i_cnt_err, i_rd_idx, i_di_lost} = '0;
    i_variant = DRC_VAR_ALARM;
    i_basic = '0;
    i_cnt_lost = '0;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_alarm();
    t_counter();
    t_basic();
    give_verdict();
  end
endmodule : tb_drc_diag_record
`default_nettype wire
